// >>> logic/adc_threshold_trigger_ctrl.sv
// Threshold, deviation, trigger select and charge pump control behind a Wishbone slave.
`timescale 1ns/1ps

module adc_threshold_trigger_ctrl #(
  parameter int unsigned IOC_W = 8
) (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              ce_i,
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [adc_thr_pkg::AW-1:0]        wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [adc_thr_pkg::DW-1:0]        wb_dat_i,
  output logic      [adc_thr_pkg::DW-1:0]        wb_dat_o,
  output logic                                   wb_ack_o,
  input  wire logic [11:0]                       result_i,
  input  wire logic                              result_valid_i,
  input  wire logic [adc_thr_pkg::HW_TRIG_N-2:0] hw_trig_i,
  input  wire logic [IOC_W-1:0]                  ioc_flags_i,
  input  wire logic                              pump_request_i,
  input  wire logic                              pump_ready_i,
  output logic                                   conv_start_o,
  output logic                                   pump_on_o,
  output logic                                   threshold_irq_o,
  output adc_thr_pkg::flags_s                    flags_o
);

  // ********************************************************************
  // Register state
  // ********************************************************************
  logic [15:0]         setpoint_value_r;
  logic [15:0]         lower_limit_r;
  logic [15:0]         upper_limit_r;
  logic [15:0]         deviation_r;
  logic [4:0]          trigger_source_code_r;
  logic                pump_enable_r;
  adc_thr_pkg::cfg_s   cfg_r;
  logic [2:0]          mode_r;
  logic [2:0]          shift_r;
  logic [7:0]          rpt_target_r;
  logic [7:0]          repeat_tally_r;
  logic [adc_thr_pkg::CHAN_W-1:0] chan_r;
  logic [17:0]         running_sum_r;
  logic [11:0]         prev_sample_r;
  logic [11:0]         last_result_r;
  logic [15:0]         filt_r;

  // ********************************************************************
  // Bus decode
  // ********************************************************************
  function automatic logic hit(input logic [adc_thr_pkg::AW-1:0] adr,
                               input logic [7:0] off);
    hit = (adr == off);
  endfunction : hit

  wire acc_w  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_w   = acc_w & wb_we_i & wb_sel_i[0];
  wire rd_w   = acc_w & ~wb_we_i;
  wire [7:0] wbyte_w = wb_dat_i[7:0];

  // Software-side trigger events, one cycle wide at bus acceptance.
  wire sw_chan_w = wr_w & hit(wb_adr_i, adc_thr_pkg::OFF_CHAN);
  wire sw_resh_w = rd_w & hit(wb_adr_i, adc_thr_pkg::OFF_RES_HI);
  wire sw_errh_w = rd_w & hit(wb_adr_i, adc_thr_pkg::OFF_DEV_HI);

  // ********************************************************************
  // Pin synchronisers and edge detection
  // ********************************************************************
  // The change flags are merged before the synchroniser so that code 21 sees one line.
  wire [adc_thr_pkg::HW_TRIG_N-1:0] pins_w =
    {hw_trig_i[adc_thr_pkg::HW_TRIG_N-2:20], |ioc_flags_i, hw_trig_i[19:0]};
  logic [adc_thr_pkg::HW_TRIG_N-1:0] sync1_r;
  logic [adc_thr_pkg::HW_TRIG_N-1:0] sync2_r;
  logic [adc_thr_pkg::HW_TRIG_N-1:0] sync3_r;
  logic [1:0]                        rdy_sync_r;

  // Only the second and third stages feed logic; the first stage may be metastable.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_r    <= '0;
      sync2_r    <= '0;
      sync3_r    <= '0;
      rdy_sync_r <= '0;
    end
    else if (ce_i)
    begin
      sync1_r    <= pins_w;
      sync2_r    <= sync1_r;
      sync3_r    <= sync2_r;
      rdy_sync_r <= {rdy_sync_r[0], pump_ready_i};
    end
  end

  // Slot k of the edge vector answers to selector code k; slot zero never fires.
  wire [31:0] hw_edge_w = {6'h00, sync2_r & ~sync3_r, 1'b0};
  wire sw_start_w =
    ((trigger_source_code_r == adc_thr_pkg::TRG_SW_CHAN) & sw_chan_w) |
    ((trigger_source_code_r == adc_thr_pkg::TRG_SW_RESH) & sw_resh_w) |
    ((trigger_source_code_r == adc_thr_pkg::TRG_SW_ERRH) & sw_errh_w);
  // Reserved codes fall on unused upper slots and never start a conversion.
  wire start_w = hw_edge_w[trigger_source_code_r] | sw_start_w;

  // ********************************************************************
  // Computation datapath
  // ********************************************************************
  wire [17:0] smp18_w = {6'h00, result_i};
  wire [17:0] lpf_w   = running_sum_r - (running_sum_r >> shift_r) + smp18_w;
  wire repeat_mode_w  = (mode_r == adc_thr_pkg::MD_AVG) |
                        (mode_r == adc_thr_pkg::MD_BURST) |
                        (mode_r == adc_thr_pkg::MD_LPF);
  wire restart_w      = repeat_mode_w & (repeat_tally_r >= rpt_target_r);
  wire [7:0] tally_nxt = restart_w ? 8'h01 :
                         (&repeat_tally_r) ? repeat_tally_r : repeat_tally_r + 8'h01;
  wire check_w        = ~repeat_mode_w | (tally_nxt >= rpt_target_r);

  logic [17:0] sum_nxt;
  // Average and burst restart their sum once a block is checked; low-pass keeps history.
  always_comb
  begin
    unique case (mode_r)
      adc_thr_pkg::MD_ACC:   sum_nxt = running_sum_r + smp18_w;
      adc_thr_pkg::MD_AVG,
      adc_thr_pkg::MD_BURST: sum_nxt = restart_w ? smp18_w : running_sum_r + smp18_w;
      adc_thr_pkg::MD_LPF:   sum_nxt = lpf_w;
      default:               sum_nxt = smp18_w;
    endcase
  end

  wire [17:0] shifted_w = sum_nxt >> shift_r;
  wire [15:0] filt_nxt  = shifted_w[15:0];
  wire [15:0] smp16_w   = {4'h0, result_i};
  wire [15:0] prev16_w  = {4'h0, prev_sample_r};

  logic [15:0] err_w;
  // The deviation is a plain 16-bit two's complement difference; it wraps, it never clips.
  always_comb
  begin
    unique case (cfg_r.deviation_mode_a)
      adc_thr_pkg::DEVIATION_MODE_A_PREV:   err_w = smp16_w - prev16_w;
      adc_thr_pkg::DEVIATION_MODE_A_FILT:   err_w = smp16_w - filt_nxt;
      adc_thr_pkg::DEVIATION_MODE_A_FSETPT: err_w = filt_nxt - setpoint_value_r;
      default:                  err_w = smp16_w - setpoint_value_r;
    endcase
  end

  wire lt_l_w = $signed(err_w) < $signed(lower_limit_r);
  wire gt_l_w = $signed(err_w) > $signed(lower_limit_r);
  wire lt_u_w = $signed(err_w) < $signed(upper_limit_r);
  wire gt_u_w = $signed(err_w) > $signed(upper_limit_r);

  logic irq_cond_w;
  always_comb
  begin
    unique case (cfg_r.tmd)
      adc_thr_pkg::TMD_NEVER:   irq_cond_w = 1'b0;
      adc_thr_pkg::TMD_LT_L:    irq_cond_w = lt_l_w;
      adc_thr_pkg::TMD_GE_L:    irq_cond_w = ~lt_l_w;
      adc_thr_pkg::TMD_INSIDE:  irq_cond_w = gt_l_w & lt_u_w;
      adc_thr_pkg::TMD_OUTSIDE: irq_cond_w = ~(gt_l_w & lt_u_w);
      adc_thr_pkg::TMD_LE_U:    irq_cond_w = ~gt_u_w;
      adc_thr_pkg::TMD_GT_U:    irq_cond_w = gt_u_w;
      adc_thr_pkg::TMD_ALWAYS:  irq_cond_w = 1'b1;
    endcase
  end

  wire compute_w = result_valid_i & check_w;

  // Sum, tally and filter advance on every finished conversion.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      running_sum_r  <= '0;
      repeat_tally_r <= adc_thr_pkg::RST_BYTE;
      prev_sample_r  <= '0;
      last_result_r  <= '0;
      filt_r         <= adc_thr_pkg::RST_WORD;
    end
    else if (ce_i && result_valid_i)
    begin
      running_sum_r  <= sum_nxt;
      repeat_tally_r <= tally_nxt;
      prev_sample_r  <= result_i;
      last_result_r  <= result_i;
      filt_r         <= filt_nxt;
    end
  end

  // Deviation and flags move only when a computation completes.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      deviation_r     <= adc_thr_pkg::RST_WORD;
      flags_o         <= '0;
      threshold_irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      threshold_irq_o <= compute_w & irq_cond_w;
      if (compute_w)
      begin
        deviation_r   <= err_w;
        flags_o.above <= gt_u_w;
        flags_o.below <= lt_l_w;
      end
    end
  end

  // ********************************************************************
  // Start and pump outputs
  // ********************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      conv_start_o <= 1'b0;
      pump_on_o    <= 1'b0;
    end
    else if (ce_i)
    begin
      conv_start_o <= start_w;
      pump_on_o    <= pump_enable_r & pump_request_i;
    end
  end

  // ********************************************************************
  // Software-written registers
  // ********************************************************************
  // Only byte lane zero carries data; a write without it is acknowledged and dropped.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      setpoint_value_r      <= adc_thr_pkg::RST_WORD;
      lower_limit_r         <= adc_thr_pkg::RST_WORD;
      upper_limit_r         <= adc_thr_pkg::RST_WORD;
      trigger_source_code_r <= adc_thr_pkg::TRG_OFF;
      pump_enable_r         <= 1'b0;
      cfg_r                 <= '0;
      mode_r                <= adc_thr_pkg::MD_BASIC;
      shift_r               <= '0;
      rpt_target_r          <= adc_thr_pkg::RST_BYTE;
      chan_r                <= '0;
    end
    else if (ce_i && wr_w)
    begin
      unique case (wb_adr_i)
        adc_thr_pkg::OFF_SETPT_LO: setpoint_value_r[7:0]  <= wbyte_w;
        adc_thr_pkg::OFF_SETPT_HI: setpoint_value_r[15:8] <= wbyte_w;
        adc_thr_pkg::OFF_LOWER_LO: lower_limit_r[7:0]     <= wbyte_w;
        adc_thr_pkg::OFF_LOWER_HI: lower_limit_r[15:8]    <= wbyte_w;
        adc_thr_pkg::OFF_UPPER_LO: upper_limit_r[7:0]     <= wbyte_w;
        adc_thr_pkg::OFF_UPPER_HI: upper_limit_r[15:8]    <= wbyte_w;
        adc_thr_pkg::OFF_TRIG_SEL: trigger_source_code_r  <= wbyte_w[4:0];
        adc_thr_pkg::OFF_PUMP:     pump_enable_r <= wbyte_w[adc_thr_pkg::PUMP_EN_BIT];
        adc_thr_pkg::OFF_CTL3:
        begin
          cfg_r.deviation_mode_a <= wbyte_w[adc_thr_pkg::DEVIATION_MODE_A_LSB +: 3];
          cfg_r.tmd  <= wbyte_w[adc_thr_pkg::TMD_LSB +: 3];
        end
        adc_thr_pkg::OFF_CMP_CTL:
        begin
          shift_r <= wbyte_w[adc_thr_pkg::SHIFT_LSB +: 3];
          mode_r  <= wbyte_w[adc_thr_pkg::MODE_LSB +: 3];
        end
        adc_thr_pkg::OFF_RPT:      rpt_target_r <= wbyte_w;
        adc_thr_pkg::OFF_CHAN:     chan_r <= wbyte_w[adc_thr_pkg::CHAN_W-1:0];
        default:                   chan_r <= chan_r;
      endcase
    end
  end

  // ********************************************************************
  // Read multiplexer and acknowledge
  // ********************************************************************
  logic [7:0] pump_b;
  logic [7:0] stat_b;
  logic [7:0] ctl3_b;
  logic [7:0] cmp_b;
  logic [7:0] rd_b;

  always_comb
  begin
    pump_b = '0;
    stat_b = '0;
    ctl3_b = '0;
    cmp_b  = '0;
    pump_b[adc_thr_pkg::PUMP_EN_BIT]  = pump_enable_r;
    pump_b[adc_thr_pkg::PUMP_RDY_BIT] = rdy_sync_r[1];
    stat_b[adc_thr_pkg::ABOVE_BIT]    = flags_o.above;
    stat_b[adc_thr_pkg::BELOW_BIT]    = flags_o.below;
    ctl3_b[adc_thr_pkg::DEVIATION_MODE_A_LSB +: 3]  = cfg_r.deviation_mode_a;
    ctl3_b[adc_thr_pkg::TMD_LSB +: 3]   = cfg_r.tmd;
    cmp_b[adc_thr_pkg::SHIFT_LSB +: 3]  = shift_r;
    cmp_b[adc_thr_pkg::MODE_LSB +: 3]   = mode_r;
    unique case (wb_adr_i)
      adc_thr_pkg::OFF_SETPT_LO: rd_b = setpoint_value_r[7:0];
      adc_thr_pkg::OFF_SETPT_HI: rd_b = setpoint_value_r[15:8];
      adc_thr_pkg::OFF_DEV_LO:   rd_b = deviation_r[7:0];
      adc_thr_pkg::OFF_DEV_HI:   rd_b = deviation_r[15:8];
      adc_thr_pkg::OFF_LOWER_LO: rd_b = lower_limit_r[7:0];
      adc_thr_pkg::OFF_LOWER_HI: rd_b = lower_limit_r[15:8];
      adc_thr_pkg::OFF_UPPER_LO: rd_b = upper_limit_r[7:0];
      adc_thr_pkg::OFF_UPPER_HI: rd_b = upper_limit_r[15:8];
      adc_thr_pkg::OFF_TRIG_SEL: rd_b = {3'h0, trigger_source_code_r};
      adc_thr_pkg::OFF_PUMP:     rd_b = pump_b;
      adc_thr_pkg::OFF_CTL3:     rd_b = ctl3_b;
      adc_thr_pkg::OFF_STATUS:   rd_b = stat_b;
      adc_thr_pkg::OFF_CMP_CTL:  rd_b = cmp_b;
      adc_thr_pkg::OFF_RPT:      rd_b = rpt_target_r;
      adc_thr_pkg::OFF_TALLY:    rd_b = repeat_tally_r;
      adc_thr_pkg::OFF_CHAN:     rd_b = {2'h0, chan_r};
      adc_thr_pkg::OFF_RES_HI:   rd_b = last_result_r[11:4];
      adc_thr_pkg::OFF_FILT_LO:  rd_b = filt_r[7:0];
      adc_thr_pkg::OFF_FILT_HI:  rd_b = filt_r[15:8];
      default:                   rd_b = adc_thr_pkg::RST_BYTE;
    endcase
  end

  // One wait-free cycle: ack follows the request by one edge and drops the next.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= acc_w;
      wb_dat_o <= rd_w ? {24'h000000, rd_b} : '0;
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_setpt_compute;
    ce_i && result_valid_i && check_w && (cfg_r.deviation_mode_a == adc_thr_pkg::DEVIATION_MODE_A_SETPT);
  endsequence

  property p_setpt_reset;
    rst_i && ce_i |=> (setpoint_value_r == adc_thr_pkg::RST_WORD) && (lower_limit_r == 16'h0000);
  endproperty
  a_setpt_reset: assert property (disable iff (1'b0) p_setpt_reset)
    else $error("setpoint or limit not cleared by reset");

  property p_dev_setpt;
    s_setpt_compute |=> deviation_r == ($past(smp16_w) - $past(setpoint_value_r));
  endproperty
  a_dev_setpt: assert property (p_dev_setpt)
    else $error("deviation does not equal sample minus setpoint");

  property p_above_flag;
    (ce_i && compute_w) |=>
      flags_o.above == ($signed($past(err_w)) > $signed($past(upper_limit_r)));
  endproperty
  a_above_flag: assert property (p_above_flag)
    else $error("above flag does not follow upper comparison");

  property p_irq_never;
    (cfg_r.tmd == adc_thr_pkg::TMD_NEVER) && ce_i |=> !threshold_irq_o;
  endproperty
  a_irq_never: assert property (p_irq_never)
    else $error("event raised while interrupt mode is never");

  property p_trig_off;
    (trigger_source_code_r == adc_thr_pkg::TRG_OFF) && ce_i |=> !conv_start_o;
  endproperty
  a_trig_off: assert property (p_trig_off)
    else $error("conversion started with triggers disabled");

  property p_sw_chan;
    (trigger_source_code_r == adc_thr_pkg::TRG_SW_CHAN) && sw_chan_w && ce_i |=> conv_start_o;
  endproperty
  a_sw_chan: assert property (p_sw_chan)
    else $error("channel write did not start a conversion");

  property p_pump_off;
    !pump_enable_r && ce_i |=> !pump_on_o;
  endproperty
  a_pump_off: assert property (p_pump_off)
    else $error("pump on while pump enable is clear");

  property p_sel_upper_zero;
    rd_w && ce_i && hit(wb_adr_i, adc_thr_pkg::OFF_TRIG_SEL) |=> wb_ack_o && wb_dat_o[7:5] == 3'h0;
  endproperty
  a_sel_upper_zero: assert property (p_sel_upper_zero)
    else $error("selector upper bits read nonzero");

  property p_ack_one;
    wb_ack_o && ce_i |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack held longer than one cycle");

endmodule : adc_threshold_trigger_ctrl

// >>> logic/adc_thr_pkg.sv
// Shared constants, codes and carrier types for the threshold and trigger block.
package adc_thr_pkg;

  // ********************************************************************
  // Bus geometry and byte addresses
  // ********************************************************************
  localparam int unsigned DW = 32;
  localparam int unsigned AW = 8;
  localparam logic [7:0] OFF_SETPT_LO = 8'h00;
  localparam logic [7:0] OFF_SETPT_HI = 8'h04;
  localparam logic [7:0] OFF_DEV_LO   = 8'h08;
  localparam logic [7:0] OFF_DEV_HI   = 8'h0C;
  localparam logic [7:0] OFF_LOWER_LO = 8'h10;
  localparam logic [7:0] OFF_LOWER_HI = 8'h14;
  localparam logic [7:0] OFF_UPPER_LO = 8'h18;
  localparam logic [7:0] OFF_UPPER_HI = 8'h1C;
  localparam logic [7:0] OFF_TRIG_SEL = 8'h20;
  localparam logic [7:0] OFF_PUMP     = 8'h24;
  localparam logic [7:0] OFF_CTL3     = 8'h28;
  localparam logic [7:0] OFF_STATUS   = 8'h2C;
  localparam logic [7:0] OFF_CMP_CTL  = 8'h30;
  localparam logic [7:0] OFF_RPT      = 8'h34;
  localparam logic [7:0] OFF_TALLY    = 8'h38;
  localparam logic [7:0] OFF_CHAN     = 8'h3C;
  localparam logic [7:0] OFF_RES_HI   = 8'h40;
  localparam logic [7:0] OFF_FILT_LO  = 8'h44;
  localparam logic [7:0] OFF_FILT_HI  = 8'h48;

  // ********************************************************************
  // Field positions and reset values
  // ********************************************************************
  localparam int unsigned PUMP_EN_BIT  = 7;
  localparam int unsigned PUMP_RDY_BIT = 0;
  localparam int unsigned ABOVE_BIT    = 6;
  localparam int unsigned BELOW_BIT    = 5;
  localparam int unsigned DEVIATION_MODE_A_LSB     = 4;
  localparam int unsigned TMD_LSB      = 0;
  localparam int unsigned SHIFT_LSB    = 4;
  localparam int unsigned MODE_LSB     = 0;
  localparam int unsigned CHAN_W       = 6;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;

  // ********************************************************************
  // Trigger source codes
  // ********************************************************************
  localparam int unsigned HW_TRIG_N   = 25;
  localparam logic [4:0]  TRG_OFF     = 5'h00;
  localparam logic [4:0]  TRG_IOC     = 5'h15;
  localparam logic [4:0]  TRG_SW_ERRH = 5'h1A;
  localparam logic [4:0]  TRG_SW_RESH = 5'h1B;
  localparam logic [4:0]  TRG_SW_CHAN = 5'h1D;

  // ********************************************************************
  // Computation, deviation and interrupt mode codes
  // ********************************************************************
  localparam logic [2:0] MD_BASIC = 3'h0;
  localparam logic [2:0] MD_ACC   = 3'h1;
  localparam logic [2:0] MD_AVG   = 3'h2;
  localparam logic [2:0] MD_BURST = 3'h3;
  localparam logic [2:0] MD_LPF   = 3'h4;
  localparam logic [2:0] DEVIATION_MODE_A_PREV   = 3'h0;
  localparam logic [2:0] DEVIATION_MODE_A_SETPT  = 3'h1;
  localparam logic [2:0] DEVIATION_MODE_A_FILT   = 3'h2;
  localparam logic [2:0] DEVIATION_MODE_A_FSETPT = 3'h4;
  localparam logic [2:0] TMD_NEVER   = 3'h0;
  localparam logic [2:0] TMD_LT_L    = 3'h1;
  localparam logic [2:0] TMD_GE_L    = 3'h2;
  localparam logic [2:0] TMD_INSIDE  = 3'h3;
  localparam logic [2:0] TMD_OUTSIDE = 3'h4;
  localparam logic [2:0] TMD_LE_U    = 3'h5;
  localparam logic [2:0] TMD_GT_U    = 3'h6;
  localparam logic [2:0] TMD_ALWAYS  = 3'h7;

  // ********************************************************************
  // Carrier types
  // ********************************************************************
  typedef struct packed {
    logic above;
    logic below;
  } flags_s;

  typedef struct packed {
    logic [2:0] deviation_mode_a;
    logic [2:0] tmd;
  } cfg_s;

endpackage : adc_thr_pkg

// >>> dv/adc_threshold_trigger_ctrl_test.sv
// Self-checking bench for the threshold, trigger and pump control block.
`timescale 1ns/1ps
module adc_threshold_trigger_ctrl_test;
  // ****************************************************************
  // Stimulus, observation and bookkeeping
  // ****************************************************************
  logic                clk_i, rst_i, cyc, stb, we, rv, preq, prdy;
  logic [7:0]          adr, ioc;
  logic [31:0]         wdat, rd, wb_dat_o;
  logic                wb_ack_o, conv_start_o, pump_on_o, threshold_irq_o;
  logic [11:0]         res;
  logic [23:0]         hw;
  adc_thr_pkg::flags_s flags_o;
  int                  miscompares, checks_done, starts, irqs, cycles;

  adc_threshold_trigger_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .result_i(res), .result_valid_i(rv),
    .hw_trig_i(hw), .ioc_flags_i(ioc), .pump_request_i(preq), .pump_ready_i(prdy),
    .conv_start_o(conv_start_o), .pump_on_o(pump_on_o), .threshold_irq_o(threshold_irq_o),
    .flags_o(flags_o));

  // Free-running clock at 250 MHz.
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Pulses are tallied so that tests judge counts and not single-edge timing.
  always @(posedge clk_i)
  begin
    cycles++;
    if (conv_start_o === 1'b1) starts++;
    if (threshold_irq_o === 1'b1) irqs++;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // One classic cycle; the request is held until ack is sampled high or 64 edges pass.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 64);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk({31'h0, wb_ack_o}, 32'h1, "no ack");
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string msg);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h000000, e}, msg);
  endtask : rdchk

  task automatic conv(input logic [11:0] r);
    @(posedge clk_i);
    rv <= 1'b1;
    res <= r;
    @(posedge clk_i);
    rv <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : conv

  task automatic pulse(input logic [23:0] h, input logic [7:0] i);
    @(posedge clk_i);
    hw <= h;
    ioc <= i;
    repeat (3) @(posedge clk_i);
    hw <= 24'h000000;
    ioc <= 8'h00;
    repeat (6) @(posedge clk_i);
  endtask : pulse

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    logic [7:0] a[8] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
    foreach (a[i]) rdchk(a[i], 8'h00, "reset value");
    bus(1'b1, adc_thr_pkg::OFF_SETPT_HI, 8'h5A);
    rdchk(adc_thr_pkg::OFF_SETPT_HI, 8'h5A, "setpoint high");
    bus(1'b1, adc_thr_pkg::OFF_DEV_LO, 8'h77);
    rdchk(adc_thr_pkg::OFF_DEV_LO, 8'h00, "deviation written");
    bus(1'b1, adc_thr_pkg::OFF_TRIG_SEL, 8'hE9);
    rdchk(adc_thr_pkg::OFF_TRIG_SEL, 8'h09, "selector top bits");
  endtask : t_regs

  // Deviation is result minus setpoint 0x0100; upper 0x0010, lower -16, irq when above.
  task automatic t_dev;
    int n;
    logic [7:0] v[7] = '{8'h00, 8'h01, 8'hF0, 8'hFF, 8'h10, 8'h00, 8'h16};
    logic [7:0] a[7] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h28};
    foreach (v[i]) bus(1'b1, a[i], v[i]);
    n = irqs;
    conv(12'h123);
    chk(irqs, n + 1, "irq above");
    chk({30'h0, flags_o}, 32'h2, "flags above");
    rdchk(adc_thr_pkg::OFF_DEV_LO, 8'h23, "deviation low");
    rdchk(adc_thr_pkg::OFF_STATUS, 8'h40, "status above");
    n = irqs;
    conv(12'h0E0);
    chk(irqs, n, "irq below");
    chk({30'h0, flags_o}, 32'h1, "flags below");
    rdchk(adc_thr_pkg::OFF_DEV_HI, 8'hFF, "deviation high");
  endtask : t_dev

  task automatic t_trig;
    int n;
    logic [7:0] c[3] = '{8'h1D, 8'h1B, 8'h1A};
    logic [7:0] a[3] = '{8'h3C, 8'h40, 8'h0C};
    bus(1'b1, adc_thr_pkg::OFF_TRIG_SEL, 8'h00);
    n = starts;
    pulse(24'hFFFFFF, 8'hFF);
    chk(starts, n, "code zero started");
    for (int k = 1; k <= 25; k++)
    begin
      bus(1'b1, adc_thr_pkg::OFF_TRIG_SEL, 8'(k));
      n = starts;
      if (k == 21) pulse(24'h000000, 8'h10);
      else pulse(24'h1 << (k < 22 ? k - 1 : k - 2), 8'h00);
      chk(starts, n + 1, "hardware trigger");
    end
    foreach (c[i])
    begin
      bus(1'b1, adc_thr_pkg::OFF_TRIG_SEL, c[i]);
      n = starts;
      bus(i == 0, a[i], 8'h05);
      repeat (3) @(posedge clk_i);
      chk(starts, n + 1, "software trigger");
    end
  endtask : t_trig

  // Average of two, then accumulate, then low-pass; ends with a reset in mid-run.
  task automatic t_deviation_mode_a;
    int n;
    bus(1'b1, adc_thr_pkg::OFF_CMP_CTL, 8'h12);
    bus(1'b1, adc_thr_pkg::OFF_RPT, 8'h02);
    bus(1'b1, adc_thr_pkg::OFF_CTL3, 8'h47);
    n = irqs;
    conv(12'h200);
    chk(irqs, n, "check before tally reached");
    conv(12'h300);
    chk(irqs, n + 1, "check at tally target");
    rdchk(adc_thr_pkg::OFF_TALLY, 8'h02, "repeat tally");
    rdchk(adc_thr_pkg::OFF_FILT_LO, 8'h80, "average filtered low");
    rdchk(adc_thr_pkg::OFF_FILT_HI, 8'h02, "average filtered high");
    rdchk(adc_thr_pkg::OFF_DEV_HI, 8'h01, "filtered minus setpoint");
    bus(1'b1, adc_thr_pkg::OFF_CMP_CTL, 8'h11);
    bus(1'b1, adc_thr_pkg::OFF_CTL3, 8'h01);
    n = irqs;
    conv(12'h100);
    chk(irqs, n + 1, "irq below lower");
    chk({30'h0, flags_o}, 32'h1, "accumulate flags");
    rdchk(adc_thr_pkg::OFF_FILT_HI, 8'h03, "accumulate filtered high");
    rdchk(adc_thr_pkg::OFF_DEV_HI, 8'hFE, "sample minus previous");
    bus(1'b1, adc_thr_pkg::OFF_CMP_CTL, 8'h14);
    bus(1'b1, adc_thr_pkg::OFF_RPT, 8'h00);
    bus(1'b1, adc_thr_pkg::OFF_CTL3, 8'h23);
    n = irqs;
    conv(12'h100);
    chk(irqs, n, "irq outside window");
    rdchk(adc_thr_pkg::OFF_FILT_HI, 8'h02, "low-pass filtered high");
    rdchk(adc_thr_pkg::OFF_DEV_HI, 8'hFF, "sample minus filtered");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({30'h0, flags_o}, 32'h0, "flags after reset");
    rdchk(adc_thr_pkg::OFF_UPPER_LO, 8'h00, "limit after reset");
    rdchk(adc_thr_pkg::OFF_SETPT_HI, 8'h00, "setpoint after reset");
  endtask : t_deviation_mode_a

  task automatic t_pump;
    bus(1'b1, adc_thr_pkg::OFF_PUMP, 8'h80);
    preq <= 1'b1;
    prdy <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({31'h0, pump_on_o}, 32'h1, "pump on");
    rdchk(adc_thr_pkg::OFF_PUMP, 8'h81, "pump ready");
    bus(1'b1, adc_thr_pkg::OFF_PUMP, 8'h00);
    repeat (3) @(posedge clk_i);
    chk({31'h0, pump_on_o}, 32'h0, "pump off");
  endtask : t_pump

  task automatic print_verdict;
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Reset for four cycles, then run every scenario in turn.
  initial
  begin
    {rst_i, cyc, stb, we, rv, preq, prdy} = 7'b1000000;
    {adr, ioc, wdat, res, hw} = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_dev();
    t_deviation_mode_a();
    t_trig();
    t_pump();
    print_verdict();
  end
endmodule : adc_threshold_trigger_ctrl_test
